// file: hdl/dsc_pkg.sv
package dsc_pkg;
  // ****************************************************************
  // register map (byte addresses, one 32-bit word each)
  // ****************************************************************
  localparam logic [7:0] DSC_ADR_CMD   = 8'h00;
  localparam logic [7:0] DSC_ADR_DH    = 8'h04;
  localparam logic [7:0] DSC_ADR_HIGH  = 8'h08;
  localparam logic [7:0] DSC_ADR_MID   = 8'h0c;
  localparam logic [7:0] DSC_ADR_LOW   = 8'h10;
  localparam logic [7:0] DSC_ADR_LEN   = 8'h14;
  localparam logic [7:0] DSC_ADR_PARM  = 8'h18;
  localparam logic [7:0] DSC_ADR_STAT  = 8'h1c;
  localparam logic [7:0] DSC_ADR_ERR   = 8'h20;
  localparam logic [7:0] DSC_ADR_DATA  = 8'h24;
  localparam logic [7:0] DSC_ADR_SEC   = 8'h28;
  // ****************************************************************
  // status and error bits
  // ****************************************************************
  localparam int         DSC_ST_ERR    = 0;
  localparam int         DSC_ST_DRQ    = 3;
  localparam int         DSC_ST_RDY    = 6;
  localparam int         DSC_ST_BSY    = 7;
  localparam logic [7:0] DSC_ERR_ABRT  = 8'h04;
  localparam logic [7:0] DSC_ERR_UNC   = 8'h40;
  // ****************************************************************
  // command codes
  // ****************************************************************
  localparam logic [7:0] DSC_CMD_NATIVE  = 8'hf8;
  localparam logic [7:0] DSC_CMD_READ    = 8'h20;
  localparam logic [7:0] DSC_CMD_VERIFY0 = 8'h40;
  localparam logic [7:0] DSC_CMD_VERIFY1 = 8'h41;
  localparam logic [7:0] DSC_CMD_SENSE   = 8'h03;
  localparam logic [7:0] DSC_CMD_PWOFF   = 8'hf6;
  localparam logic [7:0] DSC_CMD_EPREP   = 8'hf3;
  localparam logic [7:0] DSC_CMD_EUNIT   = 8'hf4;
  // ****************************************************************
  // extended error codes
  // ****************************************************************
  localparam logic [7:0] DSC_EXT_NONE    = 8'h00;
  localparam logic [7:0] DSC_EXT_MISC    = 8'h09;
  localparam logic [7:0] DSC_EXT_BADADR  = 8'h21;
  localparam logic [7:0] DSC_EXT_OVFL    = 8'h2f;
  localparam logic [7:0] DSC_EXT_UNC     = 8'h11;
  localparam logic [7:0] DSC_EXT_CORR    = 8'h18;
  localparam logic [7:0] DSC_EXT_IDNF0   = 8'h10;
  localparam logic [7:0] DSC_EXT_IDNF1   = 8'h14;
  localparam logic [7:0] DSC_EXT_SPARE   = 8'h3a;
  localparam logic [7:0] DSC_EXT_ABORT   = 8'h1f;
  localparam logic [7:0] DSC_EXT_SELFT   = 8'h05;
  localparam logic [7:0] DSC_EXT_VOLT0   = 8'h35;
  localparam logic [7:0] DSC_EXT_VOLT1   = 8'h36;
  localparam logic [7:0] DSC_EXT_WRFAIL  = 8'h03;
  // ****************************************************************
  // sizes and reset values
  // ****************************************************************
  localparam logic [8:0]  DSC_MAX_SECT  = 9'h100;
  localparam logic [7:0]  DSC_LAST_WORD = 8'hff;
  localparam logic [7:0]  DSC_PW_FIRST  = 8'h01;
  localparam logic [7:0]  DSC_PW_LAST   = 8'h10;
  localparam logic [27:0] DSC_NATIVE_MAX_DEF = 28'h0ffffff;
  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] dh;
    logic [7:0] high;
    logic [7:0] mid;
    logic [7:0] low;
    logic [7:0] len;
    logic [7:0] parm;
  } dsc_tf_s;
  typedef struct packed {
    logic        rd;
    logic        verify;
    logic [27:0] addressing_mode_bit;
  } dsc_media_s;
endpackage

// file: hdl/dsc_core.sv
`timescale 1ns/100ps
module dsc_core
  import dsc_pkg::*;
#(
  parameter logic [27:0] NATIVE_MAX = DSC_NATIVE_MAX_DEF
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output      logic [31:0] wb_dat_o,
  output      logic        wb_ack_o,
  // host interrupt
  output      logic        host_irq_o,
  // media side
  output      dsc_media_s  media_o,
  input  wire logic        media_we_i,
  input  wire logic [7:0]  media_widx_i,
  input  wire logic [15:0] media_wdata_i,
  input  wire logic        media_done_i,
  input  wire logic [7:0]  media_code_i,
  // security
  input  wire logic [255:0] user_pw_i,
  input  wire logic [255:0] master_pw_i,
  input  wire logic        frozen_i,
  input  wire logic        lock_at_reset_i,
  output      logic        lock_mode_o,
  output      logic        erase_start_o
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [1:0] {S_IDLE, S_FETCH, S_XFER, S_PW} dsc_state_e;

  dsc_state_e   state;
  dsc_tf_s      tf;
  logic         busy, data_request_flag, err;
  logic [7:0]   err_reg;
  logic [7:0]   ext_code;
  logic [8:0]   remain;
  logic [27:0]  addressing_mode_bit;
  logic [7:0]   word_idx;
  logic         pw_sel, pw_bad, armed, captured;
  logic [15:0]  sbuf [256];
  logic [255:0] pw_sel_vec;
  logic [15:0]  pw_word;
  logic [3:0]   pw_widx;
  logic         req, wr_sel, wr_cmd, wr_tf;
  logic         rd_data, wr_data, rd_stat;
  logic [7:0]   wcode;
  logic         media_ok;
  logic         pw_hit;
  logic [27:0]  tf_lba;
  logic         is_rdcmd;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_sel   = req & wb_we_i & wb_sel_i[0];
  assign wcode    = wb_dat_i[7:0];
  assign wr_cmd   = wr_sel & (wb_adr_i == DSC_ADR_CMD) & (state == S_IDLE);
  assign wr_tf    = wr_sel & (state == S_IDLE);
  assign rd_data  = req & ~wb_we_i & (wb_adr_i == DSC_ADR_DATA)
                  & (state == S_XFER || state == S_IDLE);
  assign wr_data  = wr_sel & wb_sel_i[1] & (wb_adr_i == DSC_ADR_DATA)
                  & (state == S_PW);
  assign rd_stat  = req & ~wb_we_i & (wb_adr_i == DSC_ADR_STAT);
  assign tf_lba   = {tf.dh[3:0], tf.high, tf.mid, tf.low};
  assign is_rdcmd = (wcode == DSC_CMD_READ) | (wcode == DSC_CMD_VERIFY0)
                  | (wcode == DSC_CMD_VERIFY1);
  // corrected data is good data
  assign media_ok = (media_code_i == DSC_EXT_NONE)
                  | (media_code_i == DSC_EXT_CORR);
  // password word k lives at bits 16*(k-1)
  assign pw_sel_vec = pw_sel ? master_pw_i : user_pw_i;
  assign pw_widx    = 4'(word_idx - DSC_PW_FIRST);
  assign pw_word    = pw_sel_vec[{pw_widx, 4'h0} +: 16];
  assign pw_hit     = (wb_dat_i[15:0] == pw_word);

  // ****************************************************************
  // bus answer
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h0;
      if (req && !wb_we_i) begin
        case (wb_adr_i)
          DSC_ADR_DH:   wb_dat_o[7:0] <= tf.dh;
          DSC_ADR_HIGH: wb_dat_o[7:0] <= tf.high;
          DSC_ADR_MID:  wb_dat_o[7:0] <= tf.mid;
          DSC_ADR_LOW:  wb_dat_o[7:0] <= tf.low;
          DSC_ADR_LEN:  wb_dat_o[7:0] <= tf.len;
          DSC_ADR_STAT: begin
            wb_dat_o[DSC_ST_BSY] <= busy;
            wb_dat_o[DSC_ST_RDY] <= ~busy;
            wb_dat_o[DSC_ST_DRQ] <= data_request_flag;
            wb_dat_o[DSC_ST_ERR] <= err;
          end
          DSC_ADR_ERR:  wb_dat_o[7:0] <= err_reg;
          DSC_ADR_DATA: wb_dat_o[15:0] <= sbuf[word_idx];
          DSC_ADR_SEC:  wb_dat_o[2:0] <= {armed, frozen_i, lock_mode_o};
          default:      wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // ****************************************************************
  // sector buffer
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    // never cleared on error, so flawed data stays readable
    if (media_we_i && state == S_FETCH && !media_o.verify) begin
      sbuf[media_widx_i] <= media_wdata_i;
    end
  end

  // ****************************************************************
  // lock mode
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      captured    <= 1'b0;
      lock_mode_o <= 1'b0;
    end else if (!captured) begin
      captured    <= 1'b1;
      lock_mode_o <= lock_at_reset_i;
    end else if (wr_data && word_idx == DSC_LAST_WORD && !pw_bad) begin
      // only lock mode changes; stored passwords are untouched
      lock_mode_o <= 1'b0;
    end
  end

  // ****************************************************************
  // command engine
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state         <= S_IDLE;
      tf            <= '0;
      busy          <= 1'b0;
      data_request_flag           <= 1'b0;
      err           <= 1'b0;
      err_reg       <= 8'h00;
      ext_code      <= DSC_EXT_NONE;
      remain        <= 9'h000;
      addressing_mode_bit           <= 28'h0;
      word_idx      <= 8'h00;
      pw_sel        <= 1'b0;
      pw_bad        <= 1'b0;
      armed         <= 1'b0;
      host_irq_o    <= 1'b0;
      media_o       <= '0;
      erase_start_o <= 1'b0;
    end else begin
      erase_start_o <= 1'b0;
      if (rd_stat) begin
        host_irq_o <= 1'b0;
      end
      if (rd_data) begin
        word_idx <= word_idx + 8'h01;
      end
      if (wr_tf) begin
        case (wb_adr_i)
          DSC_ADR_DH:   tf.dh   <= wcode;
          DSC_ADR_HIGH: tf.high <= wcode;
          DSC_ADR_MID:  tf.mid  <= wcode;
          DSC_ADR_LOW:  tf.low  <= wcode;
          DSC_ADR_LEN:  tf.len  <= wcode;
          DSC_ADR_PARM: tf.parm <= wcode;
          default:      ;
        endcase
      end
      case (state)
        S_IDLE: begin
          if (wr_cmd) begin
            armed      <= (wcode == DSC_CMD_EPREP);
            host_irq_o <= 1'b1;
            err        <= 1'b0;
            err_reg    <= 8'h00;
            ext_code   <= DSC_EXT_NONE;
            if (wcode == DSC_CMD_NATIVE && tf.dh[6]) begin
              tf.dh   <= {tf.dh[7:4], NATIVE_MAX[27:24]};
              tf.high <= NATIVE_MAX[23:16];
              tf.mid  <= NATIVE_MAX[15:8];
              tf.low  <= NATIVE_MAX[7:0];
            end else if (is_rdcmd && tf_lba <= NATIVE_MAX) begin
              busy           <= 1'b1;
              host_irq_o     <= 1'b0;
              state          <= S_FETCH;
              addressing_mode_bit            <= tf_lba;
              remain         <= (tf.len == 8'h00) ? DSC_MAX_SECT
                                : {1'b0, tf.len};
              media_o.rd     <= 1'b1;
              media_o.addressing_mode_bit    <= tf_lba;
              media_o.verify <= (wcode != DSC_CMD_READ);
            end else if (is_rdcmd) begin
              err      <= 1'b1;
              err_reg  <= DSC_ERR_ABRT;
              ext_code <= DSC_EXT_BADADR;
            end else if (wcode == DSC_CMD_SENSE) begin
              err_reg  <= ext_code;
            end else if (wcode == DSC_CMD_PWOFF && !frozen_i) begin
              data_request_flag      <= 1'b1;
              word_idx <= 8'h00;
              pw_bad   <= 1'b0;
              state    <= S_PW;
            end else if (wcode == DSC_CMD_EPREP) begin
              armed    <= 1'b1;
            end else if (wcode == DSC_CMD_EUNIT && armed
                         && !frozen_i) begin
              erase_start_o <= 1'b1;
            end else begin
              err      <= 1'b1;
              err_reg  <= DSC_ERR_ABRT;
              ext_code <= DSC_EXT_ABORT;
            end
          end
        end
        S_FETCH: begin
          if (media_done_i) begin
            tf.dh   <= {tf.dh[7:4], addressing_mode_bit[27:24]};
            tf.high <= addressing_mode_bit[23:16];
            tf.mid  <= addressing_mode_bit[15:8];
            tf.low  <= addressing_mode_bit[7:0];
            if (!media_ok) begin
              media_o.rd <= 1'b0;
              busy       <= 1'b0;
              err        <= 1'b1;
              err_reg    <= DSC_ERR_UNC;
              ext_code   <= media_code_i;
              word_idx   <= 8'h00;
              host_irq_o <= 1'b1;
              state      <= S_IDLE;
              if (media_o.verify) begin
                tf.len <= remain[7:0];
              end
            end else if (media_o.verify) begin
              ext_code <= media_code_i;
              if (remain == 9'h001) begin
                media_o.rd <= 1'b0;
                busy       <= 1'b0;
                host_irq_o <= 1'b1;
                tf.len     <= 8'h00;
                state      <= S_IDLE;
              end else begin
                remain      <= remain - 9'h001;
                addressing_mode_bit         <= addressing_mode_bit + 28'h1;
                media_o.addressing_mode_bit <= addressing_mode_bit + 28'h1;
              end
            end else begin
              ext_code   <= media_code_i;
              media_o.rd <= 1'b0;
              data_request_flag        <= 1'b1;
              busy       <= 1'b0;
              host_irq_o <= 1'b1;
              word_idx   <= 8'h00;
              state      <= S_XFER;
            end
          end
        end
        S_XFER: begin
          if (rd_data) begin
            if (word_idx == DSC_LAST_WORD) begin
              data_request_flag <= 1'b0;
              if (remain == 9'h001) begin
                state <= S_IDLE;
              end else begin
                remain      <= remain - 9'h001;
                addressing_mode_bit         <= addressing_mode_bit + 28'h1;
                busy        <= 1'b1;
                media_o.rd  <= 1'b1;
                media_o.addressing_mode_bit <= addressing_mode_bit + 28'h1;
                state       <= S_FETCH;
              end
            end
          end
        end
        S_PW: begin
          if (wr_data) begin
            word_idx <= word_idx + 8'h01;
            if (word_idx == 8'h00) begin
              pw_sel <= wb_dat_i[0];
            end else if (word_idx <= DSC_PW_LAST && !pw_hit) begin
              pw_bad <= 1'b1;
            end
            if (word_idx == DSC_LAST_WORD) begin
              data_request_flag        <= 1'b0;
              host_irq_o <= 1'b1;
              state      <= S_IDLE;
              if (pw_bad) begin
                err      <= 1'b1;
                err_reg  <= DSC_ERR_ABRT;
                ext_code <= DSC_EXT_ABORT;
              end
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking dsc_cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_native_load: assert property (
    wr_cmd && wcode == DSC_CMD_NATIVE && tf.dh[6]
    |=> tf.low == NATIVE_MAX[7:0] && tf.high == NATIVE_MAX[23:16]
        && !busy && host_irq_o)
    else $error("native address not returned");
  a_zero_count: assert property (
    wr_cmd && wcode == DSC_CMD_READ && tf.len == 8'h00
    && tf_lba <= NATIVE_MAX |=> remain == DSC_MAX_SECT && busy)
    else $error("zero count not 256");
  a_read_order: assert property (
    state == S_FETCH && media_done_i && media_ok && !media_o.verify
    |=> data_request_flag && !busy && host_irq_o && state == S_XFER)
    else $error("read handshake order wrong");
  a_verify_nodrq: assert property (
    media_o.verify && state == S_FETCH |-> !data_request_flag)
    else $error("data request during verify");
  a_verify_busy: assert property (
    wr_cmd && wcode == DSC_CMD_VERIFY0 && tf_lba <= NATIVE_MAX
    |=> busy ##1 busy)
    else $error("verify did not set busy");
  a_err_addr: assert property (
    state == S_FETCH && media_done_i && !media_ok
    |=> tf.low == $past(addressing_mode_bit[7:0]) && tf.mid == $past(addressing_mode_bit[15:8])
        && err && !busy && state == S_IDLE)
    else $error("error address not kept");
  a_verify_cnt: assert property (
    state == S_FETCH && media_done_i && !media_ok && media_o.verify
    |=> tf.len == $past(remain[7:0]))
    else $error("unverified count wrong");
  a_sense_code: assert property (
    wr_cmd && wcode == DSC_CMD_SENSE |=> err_reg == $past(ext_code))
    else $error("sense code not returned");
  a_pw_reject: assert property (
    wr_data && word_idx == DSC_LAST_WORD && pw_bad && lock_mode_o
    |=> lock_mode_o && err && err_reg == DSC_ERR_ABRT)
    else $error("bad password accepted");
  a_erase_guard: assert property (
    wr_cmd && wcode == DSC_CMD_EUNIT && !armed
    |=> !erase_start_o && err)
    else $error("unprepared erase not aborted");
  a_frozen_pw: assert property (
    wr_cmd && wcode == DSC_CMD_PWOFF && frozen_i
    |=> state == S_IDLE && err && !data_request_flag)
    else $error("frozen password command accepted");

  c_read_sector: cover property (
    state == S_XFER && rd_data && word_idx == DSC_LAST_WORD);
  c_verify_err: cover property (
    state == S_FETCH && media_done_i && !media_ok && media_o.verify);
  c_unlock: cover property ($fell(lock_mode_o));
  c_erase: cover property (erase_start_o);
endmodule

// file: tb/dsc_media_model.sv
`timescale 1ns/100ps
module dsc_media_model
  import dsc_pkg::*;
(
  // request and fault setup
  input  wire logic        clk_i,
  input  wire dsc_media_s  media_i,
  input  wire logic [27:0] bad_lba_i,
  input  wire logic [7:0]  bad_code_i,
  input  wire logic [1:0]  gap_i,
  // buffer fill and completion
  output      logic        we_o,
  output      logic [7:0]  widx_o,
  output      logic [15:0] wdata_o,
  output      logic        done_o,
  output      logic [7:0]  code_o
);
  // ********
  // sector fetch, buffer fill skipped on verify
  // ********
  initial begin
    we_o    = 1'b0;
    widx_o  = 8'h00;
    wdata_o = 16'h0000;
    done_o  = 1'b0;
    code_o  = 8'h00;
    forever begin
      @(posedge clk_i);
      if (media_i.rd === 1'b1) begin
        repeat (gap_i) @(posedge clk_i);
        if (media_i.verify !== 1'b1)
          for (int i = 0; i < 256; i++) begin
            we_o    <= 1'b1;
            widx_o  <= i[7:0];
            wdata_o <= media_i.addressing_mode_bit[15:0] ^ 16'(i);
            @(posedge clk_i);
          end
        we_o   <= 1'b0;
        done_o <= 1'b1;
        code_o <= (media_i.addressing_mode_bit === bad_lba_i) ? bad_code_i : 8'h00;
        @(posedge clk_i);
        done_o <= 1'b0;
        @(posedge clk_i);
      end else begin
        wdata_o <= ~wdata_o;
        code_o  <= ~code_o;
      end
    end
  end
endmodule

// file: tb/test_disk_read_and_security_commands.sv
`timescale 1ns/100ps
module test_disk_read_and_security_commands;
  import dsc_pkg::*;
  localparam logic [27:0] NMAX = 28'h0001fff;
  logic         clk_i, rst_i, cyc, stb, we, ack, irq, lock, erase, frz;
  logic         m_we, m_done;
  logic [7:0]   adr, m_idx, m_code, bcode;
  logic [31:0]  wdat, rdat, q;
  logic [15:0]  m_wd;
  logic [27:0]  base, blba, tf;
  logic [1:0]   gap;
  logic [255:0] upw, mpw;
  dsc_media_s   media;
  int           n_fail, num_checks, n_erase;
  logic [15:0]  exq[$];
  logic [7:0]   codes[19] = '{8'h21, 8'h2f, 8'h11, 8'h18, 8'h10, 8'h14,
    8'h3a, 8'h1f, 8'h05, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36,
    8'h09, 8'h03, 8'h00};
  dsc_core #(.NATIVE_MAX(NMAX)) u_dsc_core (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .host_irq_o(irq), .media_o(media), .media_we_i(m_we),
    .media_widx_i(m_idx), .media_wdata_i(m_wd), .media_done_i(m_done),
    .media_code_i(m_code), .user_pw_i(upw), .master_pw_i(mpw),
    .frozen_i(frz), .lock_at_reset_i(1'b1), .lock_mode_o(lock),
    .erase_start_o(erase));
  dsc_media_model u_dsc_media_model (.clk_i(clk_i), .media_i(media),
    .bad_lba_i(blba), .bad_code_i(bcode), .gap_i(gap), .we_o(m_we),
    .widx_o(m_idx), .wdata_o(m_wd), .done_o(m_done), .code_o(m_code));
  // ********
  // clock, bus and check tasks
  // ********
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (erase === 1'b1) n_erase++;
  task automatic chk(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 100);
    if (t >= 100) chk("ack", 0, 1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_irq();
    int t;
    t = 0;
    while (irq !== 1'b1 && t < 5000) begin
      @(posedge clk_i);
      t++;
    end
    if (t >= 5000) chk("irq", 0, 1);
    bus(1'b0, DSC_ADR_STAT, 0);
  endtask
  task automatic cmd(input logic [7:0] c);
    bus(1'b1, DSC_ADR_CMD, {24'h0, c});
    wait_irq();
  endtask
  task automatic setup(input logic [27:0] a, input logic [7:0] n);
    bus(1'b1, DSC_ADR_DH, {24'h0, 4'he, a[27:24]});
    bus(1'b1, DSC_ADR_HIGH, {24'h0, a[23:16]});
    bus(1'b1, DSC_ADR_MID, {24'h0, a[15:8]});
    bus(1'b1, DSC_ADR_LOW, {24'h0, a[7:0]});
    bus(1'b1, DSC_ADR_LEN, {24'h0, n});
    gap = 2'($urandom_range(0, 3));
  endtask
  task automatic rdtf();
    bus(1'b0, DSC_ADR_DH, 0);
    tf[27:24] = q[3:0];
    bus(1'b0, DSC_ADR_HIGH, 0);
    tf[23:16] = q[7:0];
    bus(1'b0, DSC_ADR_MID, 0);
    tf[15:8] = q[7:0];
    bus(1'b0, DSC_ADR_LOW, 0);
    tf[7:0] = q[7:0];
  endtask
  task automatic sector(input logic [27:0] a, input int n);
    for (int i = 0; i < 256; i++) exq.push_back(a[15:0] ^ 16'(i));
    for (int i = 0; i < n; i++) begin
      bus(1'b0, DSC_ADR_DATA, 0);
      chk("data", q[15:0], exq.pop_front());
    end
    exq.delete();
  endtask
  task automatic pw(input logic m, input logic [255:0] p);
    cmd(DSC_CMD_PWOFF);
    chk("pw drq", q[DSC_ST_DRQ], 1'b1);
    for (int i = 0; i < 256; i++)
      bus(1'b1, DSC_ADR_DATA, (i == 0) ? {31'h0, m} : (i <= 16) ?
        {16'h0, p[16*(i-1)+:16]} : $urandom);
    wait_irq();
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #300000;
    n_fail++;
    stop_test();
  end
  // ********
  // test sequence
  // ********
  initial begin
    {cyc, stb, we, adr, wdat, frz, gap} = '0;
    blba = '1;
    bcode = DSC_EXT_UNC;
    void'($urandom(59));
    upw = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom,
      $urandom, $urandom};
    mpw = ~upw;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    setup(28'h0, 8'h01);
    cmd(DSC_CMD_NATIVE);
    rdtf();
    chk("native", tf, NMAX);
    $display("native test done");
    base = 28'($urandom_range(0, NMAX - 300));
    setup(base, 8'h02);
    for (int s = 0; s < 2; s++) begin
      if (s == 0) cmd(DSC_CMD_READ);
      else wait_irq();
      chk("stat", {q[7], q[3], q[0]}, 3'b010);
      sector(base + s, 256);
    end
    bus(1'b0, DSC_ADR_STAT, 0);
    chk("stat end", {q[7], q[3], q[0]}, 3'b000);
    blba = base + 1;
    setup(base, 8'h03);
    cmd(DSC_CMD_READ);
    sector(base, 256);
    wait_irq();
    chk("rd err", {q[7], q[3], q[0]}, 3'b001);
    rdtf();
    chk("err lba", tf, base + 1);
    sector(base + 1, 2);
    cmd(DSC_CMD_SENSE);
    bus(1'b0, DSC_ADR_ERR, 0);
    chk("sense", q[7:0], DSC_EXT_UNC);
    $display("read test done");
    blba = base + 2;
    setup(base, 8'h04);
    cmd(DSC_CMD_VERIFY1);
    chk("vfy err", {q[7], q[3], q[0]}, 3'b001);
    bus(1'b0, DSC_ADR_LEN, 0);
    chk("vfy left", q[7:0], 8'h02);
    rdtf();
    chk("vfy lba", tf, base + 2);
    blba = '1;
    setup(base, 8'h00);
    cmd(DSC_CMD_VERIFY0);
    chk("vfy 256", {q[7], q[3], q[0]}, 3'b000);
    rdtf();
    chk("vfy last", tf, base + 255);
    foreach (codes[i]) begin
      blba = base;
      bcode = codes[i];
      setup(base, 8'h01);
      cmd(DSC_CMD_VERIFY0);
      cmd(DSC_CMD_SENSE);
      bus(1'b0, DSC_ADR_ERR, 0);
      chk("ext code", q[7:0], codes[i]);
    end
    $display("verify test done");
    chk("lock", lock, 1'b1);
    pw(1'b1, upw);
    chk("pw bad", {q[0], lock}, 2'b11);
    pw(1'b0, upw);
    chk("pw ok", {q[0], lock}, 2'b00);
    cmd(DSC_CMD_EPREP);
    cmd(DSC_CMD_EUNIT);
    chk("erase", n_erase, 1);
    cmd(DSC_CMD_EUNIT);
    chk("no prep", n_erase, 1);
    chk("no prep err", q[0], 1'b1);
    frz <= 1'b1;
    cmd(DSC_CMD_EPREP);
    cmd(DSC_CMD_EUNIT);
    chk("frozen eu", n_erase, 1);
    chk("frozen eu err", q[0], 1'b1);
    cmd(DSC_CMD_PWOFF);
    chk("frozen pw", {q[3], q[0]}, 2'b01);
    $display("security test done");
    stop_test();
  end
endmodule
